// ---- pkg/sfec_pkg.sv ----
// Constants, register map and field layout of the spatial filter engine control block.
// Assumes a word-addressed register port behind the serial configuration port.
//
// Functional notes
// - Skip bits route audio around the pre-array and array stages, one per stage.
// - Bit 30 enables the pre-array stage, bit 31 the array stage.
// - Disabling a stage never alters registers or memory contents.
// - Array tap length bits 7:0, pre-filter tap length bits 14:8.
// - Output one route bits 17:16 pick array channel 0 or 1.
// - Output two route bits 19:18 pick array channel 0 or 1.
// - Compressor threshold bits 4:0 set the compression knee level.
// - Pre-compression gain bits 7:5 double per step, 2 up to 256.
// - Ratio bits 10:8 select 1:1 up to 16:1 in documented order.
// - Post gain bits 14:12 select 1 up to 8 linear.
// - Bits 23:16 of compressor word one pick the array stage setting set.
// - Compressor word two holds two full setting sets, low and high half.
// - Debug sample bits 23:0 feed both channels; bits 31:24 unused.
// - Accumulator index bits 3:0 pick the accumulator read in debug mode.
// - Debug control bit 6 enables single-step processing.
// - Debug control bit 7 enables debug mode.
// - Channel select bits 3:0 and 19:16 pick statistics channel.
// - Mode 0000 counts samples, 0001 overflows, 1xxx magnitude patterns.
// - Mode 0010 counts frequency-error events from input arriving too fast.
// - Mode fields at 7:4, 11:8, 23:20 and 27:24.
// - Bit 15 holds the pre-filter counters cleared.
// - Bit 31 holds the array counters cleared.
// - The four count values are read only.
package sfec_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 32;
    localparam int SMP_W = 24;
    localparam int FIFO_DEPTH = 32;
    localparam int NUM_CNT = 4;

    // ==========================================================
    // Register word addresses
    localparam logic [10:0] ADDR_FILTER_CONTROL = 11'h500;
    localparam logic [10:0] ADDR_COMP_ONE = 11'h501;
    localparam logic [10:0] ADDR_COMP_TWO = 11'h502;
    localparam logic [10:0] ADDR_DBG_SAMPLE = 11'h503;
    localparam logic [10:0] ADDR_DBG_CONTROL = 11'h504;
    localparam logic [10:0] ADDR_STAT_CONTROL = 11'h505;
    localparam logic [10:0] ADDR_DBG_READBACK = 11'h506;
    localparam logic [10:0] ADDR_ACC_LOW = 11'h509;
    localparam logic [10:0] ADDR_ACC_HIGH = 11'h50a;
    localparam logic [10:0] ADDR_COMP_OUT = 11'h50b;
    localparam logic [10:0] ADDR_CNT_PRE_A = 11'h50c;
    localparam logic [10:0] ADDR_CNT_PRE_B = 11'h50d;
    localparam logic [10:0] ADDR_CNT_MAIN_A = 11'h50e;
    localparam logic [10:0] ADDR_CNT_MAIN_B = 11'h50f;

    // ==========================================================
    // Writable masks and reset values
    localparam logic [31:0] MASK_FILTER_CONTROL = 32'hf00f7fff;
    localparam logic [31:0] MASK_COMP_ONE = 32'h00ff77ff;
    localparam logic [31:0] MASK_COMP_TWO = 32'h77ff77ff;
    localparam logic [31:0] MASK_DBG_SAMPLE = 32'h00ffffff;
    localparam logic [31:0] MASK_DBG_CONTROL = 32'h000000df;
    localparam logic [31:0] MASK_STAT_CONTROL = 32'h8fff8fff;
    localparam logic [31:0] RST_FILTER_CONTROL = 32'hc1e47fff & MASK_FILTER_CONTROL;
    localparam logic [31:0] RST_COMP_ONE = 32'h00001198;
    localparam logic [31:0] RST_COMP_TWO = 32'h11b811b8;
    localparam logic [31:0] RST_DBG_SAMPLE = 32'h00000000;
    localparam logic [31:0] RST_DBG_CONTROL = 32'h00000000;
    localparam logic [31:0] RST_STAT_CONTROL = 32'h80008000;

    // ==========================================================
    // Field positions
    localparam int ARRAY_TAP_LSB = 0;
    localparam int PRE_TAP_LSB = 8;
    localparam int OUT_ONE_ROUTE_LSB = 16;
    localparam int OUT_TWO_ROUTE_LSB = 18;
    localparam int PRE_SKIP_BIT = 28;
    localparam int ARRAY_SKIP_BIT = 29;
    localparam int PRE_EN_BIT = 30;
    localparam int ARRAY_EN_BIT = 31;
    localparam int TH_LSB = 0;
    localparam int GAIN_LSB = 5;
    localparam int RATIO_LSB = 8;
    localparam int POST_LSB = 12;
    localparam int SET_W = 15;
    localparam int SET_HI_LSB = 16;
    localparam int ARRAY_SEL_LSB = 16;
    localparam int ACC_IDX_LSB = 0;
    localparam int FILTER_SEL_BIT = 4;
    localparam int STEP_BIT = 6;
    localparam int DEBUG_BIT = 7;
    localparam int PRE_CH_LSB = 0;
    localparam int PRE_A_MODE_LSB = 4;
    localparam int PRE_B_MODE_LSB = 8;
    localparam int PRE_ZERO_BIT = 15;
    localparam int MAIN_CH_LSB = 16;
    localparam int MAIN_A_MODE_LSB = 20;
    localparam int MAIN_B_MODE_LSB = 24;
    localparam int MAIN_ZERO_BIT = 31;

    // ==========================================================
    // Array set selection, counter modes, datapath scaling
    localparam logic [7:0] SEL_TWO_LOW = 8'h01;
    localparam logic [7:0] SEL_TWO_HIGH = 8'h02;
    localparam logic [3:0] MODE_SAMPLES = 4'h0;
    localparam logic [3:0] MODE_OVERFLOW = 4'h1;
    localparam logic [3:0] MODE_FREQ_ERR = 4'h2;
    localparam int MODE_MAG_BIT = 3;
    localparam int THRESH_SHIFT = 19;
    localparam int MAG_LSB = 15;
    localparam int RATIO_SHIFT = 8;
    localparam int POST_SHIFT = 2;
    localparam logic [47:0] SAT_LEVEL = 48'h0000007fffff;
    // Reciprocal of ratio in 1/256 units, index 7 first
    localparam logic [7:0][8:0] RATIO_RECIP = {9'h010, 9'h018, 9'h020, 9'h030,
                                               9'h040, 9'h060, 9'h080, 9'h100};
    // Post gain in quarter units, index 7 first
    localparam logic [7:0][5:0] POST_QUARTER = {6'h20, 6'h10, 6'h0c, 6'h0a,
                                                6'h08, 6'h06, 6'h05, 6'h04};
endpackage : sfec_pkg

// ---- core/sfec_fifo.sv ----
// Sample FIFO in front of the filter engine, flip-flop storage.
// Assumes one clock, synchronous active-high reset and a freezing clock enable.
`timescale 1ns/1ps
module sfec_fifo #(
    parameter int WIDTH = 48,
    parameter int DEPTH = 32
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0] count;
    } sfec_fifo_state_t;

    sfec_fifo_state_t s;
    sfec_fifo_state_t next_s;
    logic push;
    logic pop;

    assign o_in_ready = (s.count != (PW+1)'(DEPTH));
    assign o_out_valid = (s.count != '0);
    assign o_out_data = s.mem[s.rd_ptr];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    // ==========================================================
    // Next state
    always_comb begin
        next_s = s;
        if (push) begin
            next_s.mem[s.wr_ptr] = i_in_data;
            next_s.wr_ptr = (s.wr_ptr == PW'(DEPTH - 1)) ? '0 : s.wr_ptr + 1'b1;
        end
        if (pop) begin
            next_s.rd_ptr = (s.rd_ptr == PW'(DEPTH - 1)) ? '0 : s.rd_ptr + 1'b1;
        end
        if (push && !pop) begin
            next_s.count = s.count + 1'b1;
        end else if (pop && !push) begin
            next_s.count = s.count - 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s <= '0;
        end else if (i_ce) begin
            s <= next_s;
        end
    end
endmodule : sfec_fifo

// ---- core/sfec_engine.sv ----
// Spatial filter engine control: registers, compressor stages, routing, debug and statistics.
// Assumes a word-addressed register port from the serial interface and a sample stream in.
`timescale 1ns/1ps
module sfec_engine
    import sfec_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_rd,
    output logic [DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_smp_valid,
    output logic o_smp_ready,
    input wire logic [SMP_W-1:0] i_smp_left,
    input wire logic [SMP_W-1:0] i_smp_right,
    output logic o_out_valid,
    output logic [SMP_W-1:0] o_out_one,
    output logic [SMP_W-1:0] o_out_two,
    output logic [7:0] o_array_taps,
    output logic [6:0] o_pre_taps,
    output logic o_coef_wr_allow,
    output logic o_debug_mode,
    output logic o_acc_bank,
    output logic [3:0] o_acc_index,
    input wire logic [47:0] i_acc_data
);
    typedef struct packed {
        logic [31:0] filter_control;
        logic [31:0] compressor_control_one;
        logic [31:0] compressor_control_two;
        logic [31:0] debug_audio_sample;
        logic [31:0] debug_control;
        logic [31:0] statistics_control;
        logic [NUM_CNT-1:0][31:0] cnt;
        logic step_token;
        logic [31:0] rdata;
        logic rvalid;
        logic out_valid;
        logic [SMP_W-1:0] out_one;
        logic [SMP_W-1:0] out_two;
        logic [SMP_W-1:0] comp_out;
    } sfec_state_t;

    sfec_state_t s;
    sfec_state_t next_s;

    // ==========================================================
    // Compressor: gain, knee, ratio, post gain, saturation
    function automatic logic [SMP_W:0] compress(input logic [SMP_W-1:0] smp, input logic [SET_W-1:0] set);
        logic neg;
        logic [SMP_W-1:0] mag;
        logic [47:0] level;
        logic [47:0] thr;
        logic [47:0] post;
        logic ovf;
        logic [SMP_W-2:0] res;
        neg = smp[SMP_W-1];
        mag = neg ? (24'h000000 - smp) : smp;
        level = {24'h000000, mag} << ({1'b0, set[GAIN_LSB+:3]} + 4'h1);
        thr = 48'(set[TH_LSB+:5]) << THRESH_SHIFT;
        if (level > thr) begin
            level = thr + (((level - thr) * 48'(RATIO_RECIP[set[RATIO_LSB+:3]])) >> RATIO_SHIFT);
        end
        post = (level * 48'(POST_QUARTER[set[POST_LSB+:3]])) >> POST_SHIFT;
        ovf = post > SAT_LEVEL;
        res = ovf ? SAT_LEVEL[SMP_W-2:0] : post[SMP_W-2:0];
        return {ovf, neg ? (24'h000000 - {1'b0, res}) : {1'b0, res}};
    endfunction : compress

    // Magnitude pattern: bits 22 down to 22-n of the magnitude all set
    function automatic logic mag_hit(input logic [SMP_W-1:0] smp, input logic [2:0] n);
        logic [SMP_W-1:0] mag;
        logic [7:0] mk;
        mag = smp[SMP_W-1] ? (24'h000000 - smp) : smp;
        mk = 8'hff << (4'h7 - {1'b0, n});
        return (mag[MAG_LSB+:8] & mk) == mk;
    endfunction : mag_hit

    // Counter event decode for one counter
    function automatic logic cnt_event(input logic [3:0] mode, input logic [3:0] chsel, input logic vld,
                                       input logic [SMP_W-1:0] c0, input logic [SMP_W-1:0] c1,
                                       input logic o0, input logic o1, input logic ferr);
        logic match;
        logic [SMP_W-1:0] smp;
        logic ovf;
        match = vld && (chsel == 4'h0 || chsel == 4'h1);
        smp = chsel[0] ? c1 : c0;
        ovf = chsel[0] ? o1 : o0;
        if (mode == MODE_SAMPLES) begin
            return match;
        end else if (mode == MODE_OVERFLOW) begin
            return match && ovf;
        end else if (mode == MODE_FREQ_ERR) begin
            return ferr;
        end else begin
            return mode[MODE_MAG_BIT] && match && mag_hit(smp, mode[2:0]);
        end
    endfunction : cnt_event

    // ==========================================================
    // Input FIFO and sample source
    logic fifo_valid;
    logic fifo_pop;
    logic [2*SMP_W-1:0] fifo_data;
    logic debug_on;
    logic step_on;
    logic fire;
    logic freq_err;

    assign debug_on = s.debug_control[DEBUG_BIT];
    assign step_on = s.debug_control[STEP_BIT];
    assign fifo_pop = !debug_on && fifo_valid && (!step_on || s.step_token);
    assign fire = debug_on ? s.step_token : fifo_pop;
    assign freq_err = i_smp_valid && !o_smp_ready;

    sfec_fifo #(
        .WIDTH(2 * SMP_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_in_valid(i_smp_valid),
        .o_in_ready(o_smp_ready),
        .i_in_data({i_smp_left, i_smp_right}),
        .o_out_valid(fifo_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_data)
    );

    // ==========================================================
    // Datapath
    logic [SMP_W-1:0] src_l;
    logic [SMP_W-1:0] src_r;
    logic pre_on;
    logic array_on;
    logic [SMP_W:0] pre_cl;
    logic [SMP_W:0] pre_cr;
    logic [SMP_W-1:0] pre_l;
    logic [SMP_W-1:0] pre_r;
    logic [SET_W-1:0] array_set;
    logic [SMP_W:0] arr_cl;
    logic [SMP_W:0] arr_cr;
    logic [SMP_W-1:0] arr_l;
    logic [SMP_W-1:0] arr_r;

    assign src_l = debug_on ? s.debug_audio_sample[SMP_W-1:0] : fifo_data[2*SMP_W-1:SMP_W];
    assign src_r = debug_on ? s.debug_audio_sample[SMP_W-1:0] : fifo_data[SMP_W-1:0];
    assign pre_on = s.filter_control[PRE_EN_BIT];
    assign array_on = s.filter_control[ARRAY_EN_BIT];
    assign pre_cl = compress(src_l, s.compressor_control_one[SET_W-1:0]);
    assign pre_cr = compress(src_r, s.compressor_control_one[SET_W-1:0]);
    // Disabled stage mutes, skipped stage passes untouched
    assign pre_l = !pre_on ? '0 : (s.filter_control[PRE_SKIP_BIT] ? src_l : pre_cl[SMP_W-1:0]);
    assign pre_r = !pre_on ? '0 : (s.filter_control[PRE_SKIP_BIT] ? src_r : pre_cr[SMP_W-1:0]);

    always_comb begin
        unique case (s.compressor_control_one[ARRAY_SEL_LSB+:8])
            SEL_TWO_LOW: array_set = s.compressor_control_two[SET_W-1:0];
            SEL_TWO_HIGH: array_set = s.compressor_control_two[SET_HI_LSB+:SET_W];
            default: array_set = s.compressor_control_one[SET_W-1:0];
        endcase
    end

    assign arr_cl = compress(pre_l, array_set);
    assign arr_cr = compress(pre_r, array_set);
    assign arr_l = !array_on ? '0 : (s.filter_control[ARRAY_SKIP_BIT] ? pre_l : arr_cl[SMP_W-1:0]);
    assign arr_r = !array_on ? '0 : (s.filter_control[ARRAY_SKIP_BIT] ? pre_r : arr_cr[SMP_W-1:0]);

    // ==========================================================
    // Statistics events
    logic pre_vld;
    logic arr_vld;
    logic [NUM_CNT-1:0] hit;

    assign pre_vld = fire && pre_on;
    assign arr_vld = fire && array_on;

    always_comb begin
        hit[0] = cnt_event(s.statistics_control[PRE_A_MODE_LSB+:4], s.statistics_control[PRE_CH_LSB+:4],
                           pre_vld, pre_l, pre_r, pre_cl[SMP_W], pre_cr[SMP_W], freq_err);
        hit[1] = cnt_event(s.statistics_control[PRE_B_MODE_LSB+:4], s.statistics_control[PRE_CH_LSB+:4],
                           pre_vld, pre_l, pre_r, pre_cl[SMP_W], pre_cr[SMP_W], freq_err);
        hit[2] = cnt_event(s.statistics_control[MAIN_A_MODE_LSB+:4], s.statistics_control[MAIN_CH_LSB+:4],
                           arr_vld, arr_l, arr_r, arr_cl[SMP_W], arr_cr[SMP_W], freq_err);
        hit[3] = cnt_event(s.statistics_control[MAIN_B_MODE_LSB+:4], s.statistics_control[MAIN_CH_LSB+:4],
                           arr_vld, arr_l, arr_r, arr_cl[SMP_W], arr_cr[SMP_W], freq_err);
    end

    // ==========================================================
    // Next state
    always_comb begin
        next_s = s;
        next_s.rvalid = 1'b0;
        next_s.out_valid = 1'b0;
        if (fire) begin
            next_s.out_valid = 1'b1;
            next_s.out_one = s.filter_control[OUT_ONE_ROUTE_LSB] ? arr_r : arr_l;
            next_s.out_two = s.filter_control[OUT_TWO_ROUTE_LSB] ? arr_r : arr_l;
            next_s.comp_out = arr_l;
            if (debug_on || step_on) begin
                next_s.step_token = 1'b0;
            end
        end
        for (int i = 0; i < NUM_CNT; i++) begin
            if (s.statistics_control[(i < 2) ? PRE_ZERO_BIT : MAIN_ZERO_BIT]) begin
                next_s.cnt[i] = '0;
            end else if (hit[i] && s.cnt[i] != 32'hffffffff) begin
                next_s.cnt[i] = s.cnt[i] + 32'h00000001;
            end
        end
        // Register writes; disabling a stage touches nothing else
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                ADDR_FILTER_CONTROL: next_s.filter_control = i_reg_wdata & MASK_FILTER_CONTROL;
                ADDR_COMP_ONE: next_s.compressor_control_one = i_reg_wdata & MASK_COMP_ONE;
                ADDR_COMP_TWO: next_s.compressor_control_two = i_reg_wdata & MASK_COMP_TWO;
                ADDR_DBG_SAMPLE: begin
                    next_s.debug_audio_sample = i_reg_wdata & MASK_DBG_SAMPLE;
                    next_s.step_token = 1'b1;
                end
                ADDR_DBG_CONTROL: next_s.debug_control = i_reg_wdata & MASK_DBG_CONTROL;
                ADDR_STAT_CONTROL: next_s.statistics_control = i_reg_wdata & MASK_STAT_CONTROL;
                default: ;
            endcase
        end
        if (i_reg_rd) begin
            next_s.rvalid = 1'b1;
            unique case (i_reg_addr)
                ADDR_FILTER_CONTROL: next_s.rdata = s.filter_control;
                ADDR_COMP_ONE: next_s.rdata = s.compressor_control_one;
                ADDR_COMP_TWO: next_s.rdata = s.compressor_control_two;
                ADDR_DBG_SAMPLE: next_s.rdata = s.debug_audio_sample;
                ADDR_DBG_CONTROL: next_s.rdata = s.debug_control;
                ADDR_STAT_CONTROL: next_s.rdata = s.statistics_control;
                ADDR_DBG_READBACK: next_s.rdata = {8'h00, s.out_one};
                ADDR_ACC_LOW: next_s.rdata = debug_on ? i_acc_data[31:0] : 32'h00000000;
                ADDR_ACC_HIGH: next_s.rdata = debug_on ? {16'h0000, i_acc_data[47:32]} : 32'h00000000;
                ADDR_COMP_OUT: next_s.rdata = {8'h00, s.comp_out};
                ADDR_CNT_PRE_A: next_s.rdata = s.cnt[0];
                ADDR_CNT_PRE_B: next_s.rdata = s.cnt[1];
                ADDR_CNT_MAIN_A: next_s.rdata = s.cnt[2];
                ADDR_CNT_MAIN_B: next_s.rdata = s.cnt[3];
                default: next_s.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s <= '0;
            s.filter_control <= RST_FILTER_CONTROL;
            s.compressor_control_one <= RST_COMP_ONE;
            s.compressor_control_two <= RST_COMP_TWO;
            s.debug_audio_sample <= RST_DBG_SAMPLE;
            s.debug_control <= RST_DBG_CONTROL;
            s.statistics_control <= RST_STAT_CONTROL;
        end else if (i_ce) begin
            s <= next_s;
        end
    end

    // ==========================================================
    // Outputs
    assign o_reg_rdata = s.rdata;
    assign o_reg_rvalid = s.rvalid;
    assign o_out_valid = s.out_valid;
    assign o_out_one = s.out_one;
    assign o_out_two = s.out_two;
    assign o_array_taps = s.filter_control[ARRAY_TAP_LSB+:8];
    assign o_pre_taps = s.filter_control[PRE_TAP_LSB+:7];
    assign o_coef_wr_allow = debug_on;
    assign o_debug_mode = debug_on;
    assign o_acc_bank = s.debug_control[FILTER_SEL_BIT];
    assign o_acc_index = s.debug_control[ACC_IDX_LSB+:4];
endmodule : sfec_engine

// ---- testbench/sfec_engine_sva.sv ----
// Port checks for the engine's register, debug and stream outputs.
// Assumes binding to sfec_engine; one clock, sync reset.
`timescale 1ns/1ps
module sfec_engine_sva
    import sfec_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [DATA_W-1:0] i_reg_wdata,
    input wire logic i_reg_rd,
    input wire logic [DATA_W-1:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    input wire logic o_out_valid,
    input wire logic [7:0] o_array_taps,
    input wire logic [6:0] o_pre_taps,
    input wire logic o_coef_wr_allow,
    input wire logic o_debug_mode,
    input wire logic o_acc_bank,
    input wire logic [3:0] o_acc_index
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    // ====
    // Access steps
    sequence wr_at(logic [10:0] a);
        i_ce && i_reg_wr && i_reg_addr == a;
    endsequence
    sequence dbg_wr;
        wr_at(ADDR_DBG_SAMPLE) ##0 o_debug_mode;
    endsequence
    // ====
    // Properties
    AST_RV_PULSE: assert property (i_ce && i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    AST_RV_ONLY: assert property (i_ce && !i_reg_rd |=> !o_reg_rvalid)
        else $error("read valid without read");
    AST_UNUSED: assert property (i_ce && i_reg_rd && i_reg_addr == ADDR_DBG_CONTROL |=>
        (o_reg_rdata & ~MASK_DBG_CONTROL) == 32'h0) else $error("unused bits not zero");
    AST_TAPS: assert property (wr_at(ADDR_FILTER_CONTROL) |=> o_array_taps == $past(i_reg_wdata[7:0])
        && o_pre_taps == $past(i_reg_wdata[14:8])) else $error("tap lengths wrong");
    AST_DBG_MODE: assert property (wr_at(ADDR_DBG_CONTROL) |=> o_debug_mode == $past(i_reg_wdata[7])
        && o_coef_wr_allow == $past(i_reg_wdata[7])) else $error("debug mode wrong");
    AST_ACC_IDX: assert property (wr_at(ADDR_DBG_CONTROL) |=> o_acc_index == $past(i_reg_wdata[3:0]))
        else $error("accumulator index wrong");
    AST_ACC_BANK: assert property (wr_at(ADDR_DBG_CONTROL) |=> o_acc_bank == $past(i_reg_wdata[4]))
        else $error("accumulator bank wrong");
    AST_DBG_SMP: assert property (dbg_wr |-> ##2 o_out_valid)
        else $error("debug sample not processed");
endmodule : sfec_engine_sva
bind sfec_engine sfec_engine_sva chk_u (.i_sys_clk, .i_rst, .i_ce, .i_reg_addr, .i_reg_wr, .i_reg_wdata,
    .i_reg_rd, .o_reg_rdata, .o_reg_rvalid, .o_out_valid, .o_array_taps, .o_pre_taps, .o_coef_wr_allow,
    .o_debug_mode, .o_acc_bank, .o_acc_index);

// ---- testbench/sfec_core_model.sv ----
// Filter core stand-in giving a distinct accumulator per bank and index.
// Assumes bank and index are levels from the engine.
`timescale 1ns/1ps
module sfec_core_model (
    input wire logic i_acc_bank,
    input wire logic [3:0] i_acc_index,
    output logic [47:0] o_acc_data
);
    assign o_acc_data = {16'h00a5, 3'h0, i_acc_bank, i_acc_index, 24'h5a5a5a};
endmodule : sfec_core_model

// ---- testbench/sfec_engine_tb.sv ----
// Self-checking bench for the filter engine control block.
// Assumes sfec_engine, its bound checker and the core stand-in.
`timescale 1ns/1ps
module sfec_engine_tb;
    import sfec_pkg::*;
    logic i_sys_clk = 1'b0;
    logic i_rst = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sv = 1'b0;
    logic [10:0] addr = '0;
    logic [31:0] wdata = '0;
    logic [23:0] sl = '0;
    logic [23:0] sr = '0;
    logic [31:0] rdata;
    logic [23:0] one, two;
    logic [7:0] atap;
    logic [6:0] ptap;
    logic [3:0] idx;
    logic [47:0] acc;
    logic rvalid, ready, ovalid, bank, coef, dbgm;
    int n_mismatch = 0;
    int n_compared = 0;
    int n_out = 0;
    int cyc = 0;
    logic [10:0] ra [6] = '{ADDR_FILTER_CONTROL, ADDR_COMP_ONE, ADDR_COMP_TWO, ADDR_DBG_SAMPLE,
        ADDR_DBG_CONTROL, ADDR_STAT_CONTROL};
    logic [31:0] rr [6] = '{RST_FILTER_CONTROL, RST_COMP_ONE, RST_COMP_TWO, RST_DBG_SAMPLE, RST_DBG_CONTROL,
        RST_STAT_CONTROL};
    logic [31:0] rm [6] = '{MASK_FILTER_CONTROL, MASK_COMP_ONE, MASK_COMP_TWO, MASK_DBG_SAMPLE,
        MASK_DBG_CONTROL, MASK_STAT_CONTROL};
    sfec_engine dut_u (.i_sys_clk, .i_rst, .i_ce(1'b1), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
        .i_reg_rd(rd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_smp_valid(sv), .o_smp_ready(ready),
        .i_smp_left(sl), .i_smp_right(sr), .o_out_valid(ovalid), .o_out_one(one), .o_out_two(two),
        .o_array_taps(atap), .o_pre_taps(ptap), .o_coef_wr_allow(coef), .o_debug_mode(dbgm),
        .o_acc_bank(bank), .o_acc_index(idx), .i_acc_data(acc));
    sfec_core_model core_u (.i_acc_bank(bank), .i_acc_index(idx), .o_acc_data(acc));
    // ====
    // Clock, output count, watchdog
    initial forever #2 i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        cyc++;
        if (ovalid === 1'b1) n_out++;
        if (cyc == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    // ====
    // Access tasks
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wreg(input logic [10:0] a, input logic [31:0] d);
        @(negedge i_sys_clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge i_sys_clk);
        wr = 1'b0;
    endtask : wreg
    task automatic rchk(input logic [10:0] a, input logic [31:0] e);
        @(negedge i_sys_clk);
        addr = a;
        rd = 1'b1;
        @(negedge i_sys_clk);
        rd = 1'b0;
        chk("rvalid", 1, rvalid);
        chk("rdata", e, rdata);
    endtask : rchk
    task automatic push(input logic [23:0] l, input logic [23:0] r);
        @(negedge i_sys_clk);
        sv = 1'b1;
        sl = l;
        sr = r;
        while (ready !== 1'b1) @(negedge i_sys_clk);
        @(negedge i_sys_clk);
        sv = 1'b0;
        sl = ~l;
        sr = ~r;
    endtask : push
    task automatic wout(input int n);
        for (int k = 0; k < 100 && n_out < n; k++) @(negedge i_sys_clk);
        chk("outputs", n, n_out);
    endtask : wout
    task automatic summarize();
        if (n_mismatch == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // ====
    // Tests
    initial begin
        repeat (16) @(negedge i_sys_clk);
        i_rst = 1'b0;
        for (int i = 0; i < 6; i++) begin
            rchk(ra[i], rr[i]);
            wreg(ra[i], 32'hffffffff);
            rchk(ra[i], rm[i]);
            wreg(ra[i], rr[i]);
        end
        chk("outputs", 1, n_out);
        n_out = 0;
        wreg(ADDR_CNT_PRE_A, 32'h00000005);
        rchk(ADDR_CNT_PRE_A, 32'h0);
        rchk(11'h5ff, 32'h0);
        for (int k = 0; k < 2; k++) begin
            wreg(ADDR_FILTER_CONTROL, k ? 32'hf0040f0f : 32'hf0010f0f);
            push(24'h000123, 24'h400000);
            wout(k + 1);
            chk("out one", k ? 32'h123 : 32'h400000, {8'h00, one});
            chk("out two", k ? 32'h400000 : 32'h123, {8'h00, two});
        end
        wreg(ADDR_FILTER_CONTROL, 32'h30010f0f);
        push(24'h000123, 24'h400000);
        wout(3);
        chk("out one", 32'h0, {8'h00, one});
        rchk(ADDR_FILTER_CONTROL, 32'h30010f0f);
        chk("taps", 32'h0f0f, {17'h0, ptap, atap});
        wreg(ADDR_FILTER_CONTROL, 32'hf0010f0f);
        wreg(ADDR_STAT_CONTROL, 32'h08010200);
        wreg(ADDR_DBG_CONTROL, 32'h00000040);
        for (int k = 0; k < FIFO_DEPTH; k++) push(24'h000123, 24'h400000);
        chk("outputs", 3, n_out);
        chk("ready", 0, ready);
        @(negedge i_sys_clk);
        sv = 1'b1;
        @(negedge i_sys_clk);
        sv = 1'b0;
        wreg(ADDR_DBG_SAMPLE, 32'h0);
        wout(4);
        chk("ready", 1, ready);
        wreg(ADDR_DBG_CONTROL, 32'h0);
        wout(35);
        for (int i = 0; i < 4; i++) rchk(ADDR_CNT_PRE_A + 11'(i), i == 1 ? 32'd1 : 32'd32);
        wreg(ADDR_STAT_CONTROL, 32'h88018200);
        rchk(ADDR_CNT_PRE_A, 32'h0);
        rchk(ADDR_CNT_MAIN_B, 32'h0);
        wreg(ADDR_DBG_CONTROL, 32'h00000095);
        wreg(ADDR_DBG_SAMPLE, 32'hff000321);
        wout(36);
        chk("out one", 32'h321, {8'h00, one});
        chk("out two", 32'h321, {8'h00, two});
        rchk(ADDR_ACC_LOW, 32'h155a5a5a);
        wreg(ADDR_FILTER_CONTROL, 32'h20010f0f);
        wreg(ADDR_COMP_ONE, 32'h000071e0);
        wreg(ADDR_FILTER_CONTROL, 32'he0010f0f);
        wreg(ADDR_STAT_CONTROL, 32'h00000010);
        wreg(ADDR_DBG_SAMPLE, 32'h00000010);
        wout(37);
        chk("out one", 32'h4000, {8'h00, one});
        wreg(ADDR_DBG_SAMPLE, 32'h00400000);
        wout(38);
        chk("out one", 32'h7fffff, {8'h00, one});
        rchk(ADDR_CNT_PRE_A, 32'd1);
        summarize();
    end
endmodule : sfec_engine_tb
